//--- ebc_map.vh
`ifndef EBC_MAP_VH
`define EBC_MAP_VH

// Timing: system clock period and bus clock period, in nanoseconds.
`define EBC_SYS_PERIOD_NS   100
`define EBC_BUS_PERIOD_NS   400
// System clocks per bus clock, derived from the two periods.
`define EBC_BUS_DIV         (`EBC_BUS_PERIOD_NS / `EBC_SYS_PERIOD_NS)
`define EBC_PHASE_W         2

// Phase indices inside one bus clock period.
`define EBC_PH_FALL         2'h1
`define EBC_PH_RISE         2'h3
`define EBC_PH_HIGH_LAST    2'h1

// Bus state encodings.
`define EBC_ST_IDLE         3'h0
`define EBC_ST_ADDR         3'h1
`define EBC_ST_DATA         3'h2
`define EBC_ST_WAIT         3'h3
`define EBC_ST_END          3'h4
`define EBC_ST_HOLD         3'h5

// Widths of the bus.
`define EBC_AD_W            16
`define EBC_CS_W            4
`define EBC_BLK_W           2

// Reset values of pins while idle.
`define EBC_CS_IDLE         4'hF
`define EBC_AD_FLOAT        16'hFFFF
`define EBC_AD_ZERO         16'h0000

`endif

//--- ebc_bus_control.v
`timescale 1ns/1ns
`default_nettype none
`include "ebc_map.vh"

// Contract
// [RL1] Hold request floats buses after current cycle.
// [RL2] Acknowledge after release; buses float meanwhile.
// [RL3] Hold request is asynchronous; synchronise first.
// [RL4] Wait sampled at bus clock fall; extends.
// [RL5] Wait ignored unless wait function enabled.
// [RL6] Four chip selects, one per block.
// [RL7] Chip selects deasserted while bus idle.
// [RL8] Low byte write strobe for low byte.
// [RL9] High byte write strobe for high byte.
// [RL10] One read strobe for read cycles.
// [RL11] Latch strobe low address phase, high end.
// [RL12] Latch strobe high when no cycle active.
// [RL13] Sixteen lines carry address then data.
// [RL14] Bus clock driven out on its pin.
// [RL15] Each pin configurable per bit as port.
// [RL16] Async low reset overrides everything.
// [RL17] Reset also leaves standby modes.
// [RL18] Phases address, data, waits, end, idle.
// [RL19] Wait and hold pass two-stage synchronisers.
module ebc_bus_control (
  // Clock and reset.
  input  wire                    i_clock,
  input  wire                    i_nrst,
  // Internal access request side.
  input  wire                    i_req,
  input  wire                    i_write,
  input  wire [`EBC_BLK_W-1:0]   i_block,
  input  wire [`EBC_AD_W-1:0]    i_addr,
  input  wire [`EBC_AD_W-1:0]    i_wdata,
  input  wire [1:0]              i_byte_en,
  output wire                    o_ready,
  output reg                     o_ack,
  output reg  [`EBC_AD_W-1:0]    o_rdata,
  // Mode and standby control.
  input  wire                    i_port_cm_function_control,
  input  wire [`EBC_AD_W-1:0]    i_ad_control_mode,
  input  wire [`EBC_AD_W-1:0]    i_port_dir_out,
  input  wire [`EBC_AD_W-1:0]    i_port_out_data,
  output reg  [`EBC_AD_W-1:0]    o_port_in_data,
  input  wire                    i_standby_enter,
  output reg                     o_standby,
  // External pins.
  input  wire                    i_bus_hold_request,
  input  wire                    i_wait,
  output reg                     o_bus_hold_acknowledge,
  output reg                     o_bus_clock_output,
  input  wire [`EBC_AD_W-1:0]    i_muxed_addr_data_bus,
  output reg  [`EBC_AD_W-1:0]    o_muxed_addr_data_bus,
  output reg  [`EBC_AD_W-1:0]    o_muxed_addr_data_bus_oe_n,
  output reg  [`EBC_CS_W-1:0]    o_block_chip_select_n,
  output reg                     o_read_strobe_n,
  output reg                     o_low_byte_write_strobe_n,
  output reg                     o_high_byte_write_strobe_n,
  output reg                     o_address_latch_strobe,
  output wire                    o_control_bus_oe_n
);

  // Reset release synchroniser; assertion stays asynchronous.
  reg                   rst_meta;
  reg                   rst_n;
  // Pin synchronisers.
  reg                   hold_meta;
  reg                   hold_sync;
  reg                   wait_meta;
  reg                   wait_sync;
  reg [`EBC_AD_W-1:0]   ad_meta;
  reg [`EBC_AD_W-1:0]   ad_sync;
  // Bus clock divider.
  reg [`EBC_PHASE_W-1:0] phase;
  wire                  rise_en;
  wire                  fall_en;
  // Bus state machine.
  reg [2:0]             state;
  reg [2:0]             next_state;
  reg                   wait_hit;
  reg                   cyc_write;
  reg [`EBC_BLK_W-1:0]  cyc_block;
  reg [`EBC_AD_W-1:0]   cyc_addr;
  reg [`EBC_AD_W-1:0]   cyc_wdata;
  reg [1:0]             cyc_be;
  wire                  take;
  wire                  floated;
  reg [`EBC_AD_W-1:0]   bus_ad;
  reg                   bus_ad_drive;

  // Reset is taken at once and released over two edges.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0; // RL16
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Hold, wait and the bus input lines arrive with no relation to our clock.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_meta <= 1'b0;
      hold_sync <= 1'b0;
      wait_meta <= 1'b0;
      wait_sync <= 1'b0;
      ad_meta   <= `EBC_AD_ZERO;
      ad_sync   <= `EBC_AD_ZERO;
    end else begin
      hold_meta <= i_bus_hold_request; // RL3
      hold_sync <= hold_meta;          // RL19
      wait_meta <= i_wait;
      wait_sync <= wait_meta;          // RL19
      ad_meta   <= i_muxed_addr_data_bus;
      ad_sync   <= ad_meta;
    end
  end

  // Divider making the bus clock; each state lasts a whole number of bus clocks.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign rise_en = (phase == `EBC_PH_RISE);
  assign fall_en = (phase == `EBC_PH_FALL);

  // The bus clock pin is high for the first half period, registered.
  // It resets high because phase 0 is a high phase: a low reset value would
  // give a one-cycle high pulse as the divider starts.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_clock_output <= 1'b1;
    end else begin
      o_bus_clock_output <= (phase == `EBC_PH_RISE) || (phase == 2'h0); // RL14
    end
  end

  // Standby holds off accesses; only a reset brings the device out of it.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_standby <= 1'b0; // RL17
    end else if (i_standby_enter && state == `EBC_ST_IDLE) begin
      o_standby <= 1'b1;
    end
  end

  // A new access is taken only at a bus clock boundary while idle.
  assign o_ready = (state == `EBC_ST_IDLE) && !hold_sync && !o_standby && rst_n;
  assign take    = o_ready && i_req && rise_en;

  // Next state; hold is only honoured from idle, so a running cycle completes.
  always @* begin
    next_state = state;
    case (state)
      `EBC_ST_IDLE: begin
        if (hold_sync) begin
          next_state = `EBC_ST_HOLD; // RL1
        end else if (take) begin
          next_state = `EBC_ST_ADDR; // RL18
        end
      end
      `EBC_ST_ADDR: begin
        next_state = `EBC_ST_DATA; // RL18
      end
      `EBC_ST_DATA, `EBC_ST_WAIT: begin
        if (wait_hit) begin
          next_state = `EBC_ST_WAIT; // RL4
        end else begin
          next_state = `EBC_ST_END;
        end
      end
      `EBC_ST_END: begin
        next_state = `EBC_ST_IDLE; // RL18
      end
      `EBC_ST_HOLD: begin
        if (!hold_sync && !o_bus_hold_acknowledge) begin
          next_state = `EBC_ST_IDLE;
        end
      end
      default: begin
        next_state = `EBC_ST_IDLE;
      end
    endcase
  end

  // States move on rising bus clock edges only.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= `EBC_ST_IDLE;
    end else if (rise_en) begin
      state <= next_state;
    end
  end

  // Wait is looked at on the falling edge of data and wait states only.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      wait_hit <= 1'b0;
    end else if (fall_en) begin
      if ((state == `EBC_ST_DATA) || (state == `EBC_ST_WAIT)) begin
        wait_hit <= wait_sync && i_port_cm_function_control; // RL4 RL5
      end else begin
        wait_hit <= 1'b0;
      end
    end
  end

  // Access fields are frozen for the whole cycle.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_write <= 1'b0;
      cyc_block <= 2'h0;
      cyc_addr  <= `EBC_AD_ZERO;
      cyc_wdata <= `EBC_AD_ZERO;
      cyc_be    <= 2'h0;
    end else if (take) begin
      cyc_write <= i_write;
      cyc_block <= i_block;
      cyc_addr  <= i_addr;
      cyc_wdata <= i_wdata;
      cyc_be    <= i_byte_en;
    end
  end

  // Read data is captured as the end phase closes, with the answer pulse.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_ack   <= 1'b0;
      o_rdata <= `EBC_AD_ZERO;
    end else begin
      o_ack <= rise_en && (state == `EBC_ST_END);
      if (rise_en && state == `EBC_ST_END && !cyc_write) begin
        o_rdata <= ad_sync;
      end
    end
  end

  // Acknowledge rises one bus clock after the buses float, and falls
  // one bus clock before they are driven again.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_hold_acknowledge <= 1'b0;
    end else if (rise_en) begin
      o_bus_hold_acknowledge <= (state == `EBC_ST_HOLD) && hold_sync; // RL2
    end
  end

  assign floated = (state == `EBC_ST_HOLD);

  // Control pins stop driving for the whole hold.
  assign o_control_bus_oe_n = floated; // RL2

  // Chip select follows the addressed block from address to end phase.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_block_chip_select_n <= `EBC_CS_IDLE;
    end else begin
      case (next_state == state ? state : (rise_en ? next_state : state))
        `EBC_ST_ADDR, `EBC_ST_DATA, `EBC_ST_WAIT, `EBC_ST_END: begin
          o_block_chip_select_n <= ~(4'h1 << cyc_block_next(take, i_block, cyc_block)); // RL6
        end
        default: begin
          o_block_chip_select_n <= `EBC_CS_IDLE; // RL7
        end
      endcase
    end
  end

  // The block taken this very edge is not yet in cyc_block.
  function [`EBC_BLK_W-1:0] cyc_block_next;
    input                  tk;
    input [`EBC_BLK_W-1:0] nb;
    input [`EBC_BLK_W-1:0] ob;
    begin
      cyc_block_next = tk ? nb : ob;
    end
  endfunction

  // Latch strobe falls mid address phase and rises mid end phase.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_address_latch_strobe <= 1'b1;
    end else if (fall_en) begin
      if (state == `EBC_ST_ADDR) begin
        o_address_latch_strobe <= 1'b0; // RL11
      end else if (state == `EBC_ST_END || state == `EBC_ST_IDLE || floated) begin
        o_address_latch_strobe <= 1'b1; // RL11 RL12
      end
    end
  end

  // Strobes are active from the start of data to the start of end phase,
  // so data is stable on the lines at their rising edge; the address stays on them one clock past the fall.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_read_strobe_n            <= 1'b1;
      o_low_byte_write_strobe_n  <= 1'b1;
      o_high_byte_write_strobe_n <= 1'b1;
    end else if (rise_en) begin
      if (next_state == `EBC_ST_DATA || next_state == `EBC_ST_WAIT) begin
        o_read_strobe_n            <= cyc_write;                   // RL10
        o_low_byte_write_strobe_n  <= !(cyc_write && cyc_be[0]);   // RL8
        o_high_byte_write_strobe_n <= !(cyc_write && cyc_be[1]);   // RL9
      end else begin
        o_read_strobe_n            <= 1'b1;
        o_low_byte_write_strobe_n  <= 1'b1;
        o_high_byte_write_strobe_n <= 1'b1;
      end
    end
  end

  // What the bus function wants on the shared lines in each phase.
  always @* begin
    bus_ad       = `EBC_AD_ZERO;
    bus_ad_drive = 1'b0;
    case (state)
      `EBC_ST_ADDR: begin
        bus_ad       = cyc_addr; // RL13
        bus_ad_drive = 1'b1;
      end
      `EBC_ST_DATA, `EBC_ST_WAIT, `EBC_ST_END: begin
        bus_ad       = cyc_wdata; // RL13
        bus_ad_drive = cyc_write;
      end
      default: begin
        bus_ad       = `EBC_AD_ZERO;
        bus_ad_drive = 1'b0;
      end
    endcase
  end

  // Each line is a bus line or a plain port line, chosen bit by bit.
  // A port line keeps its direction even during hold, since hold only
  // concerns the bus function.
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_muxed_addr_data_bus      <= `EBC_AD_ZERO;
      o_muxed_addr_data_bus_oe_n <= `EBC_AD_FLOAT;
      o_port_in_data             <= `EBC_AD_ZERO;
    end else begin
      o_muxed_addr_data_bus <= (i_ad_control_mode & bus_ad) |
                               (~i_ad_control_mode & i_port_out_data); // RL15
      o_muxed_addr_data_bus_oe_n <= (i_ad_control_mode & {`EBC_AD_W{~bus_ad_drive | floated}}) |
                                    (~i_ad_control_mode & ~i_port_dir_out); // RL15 RL1
      o_port_in_data <= ad_sync;
    end
  end

endmodule

`default_nettype wire

//--- ebc_bus_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebc_map.vh"

// Pin-level checks of the bus controller; it sees nothing but the top ports.
module ebc_bus_sva (
  // Clock and reset.
  input wire logic                 i_clock,
  input wire logic                 i_nrst,
  // Inputs that qualify the pins.
  input wire logic                 i_wait,
  input wire logic                 i_port_cm_function_control,
  input wire logic                 i_bus_hold_request,
  input wire logic [`EBC_AD_W-1:0] i_ad_control_mode,
  // Outputs under watch.
  input wire logic                 o_ready,
  input wire logic                 o_standby,
  input wire logic                 o_bus_hold_acknowledge,
  input wire logic                 o_bus_clock_output,
  input wire logic [`EBC_AD_W-1:0] o_muxed_addr_data_bus_oe_n,
  input wire logic [`EBC_CS_W-1:0] o_block_chip_select_n,
  input wire logic                 o_read_strobe_n,
  input wire logic                 o_low_byte_write_strobe_n,
  input wire logic                 o_high_byte_write_strobe_n,
  input wire logic                 o_address_latch_strobe,
  input wire logic                 o_control_bus_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // High when any read or write strobe is active.
  wire any_strobe = !(o_read_strobe_n && o_low_byte_write_strobe_n && o_high_byte_write_strobe_n);

  // Select and strobe relations; a stuck decoder shows up as two selects or an orphan strobe.
  chk_cs_single: assert property (!o_control_bus_oe_n |-> $onehot0(~o_block_chip_select_n))
    else $error("two chip selects low");
  chk_strobe_sel: assert property (any_strobe |-> o_block_chip_select_n != 4'hF
    && (o_read_strobe_n || (o_low_byte_write_strobe_n && o_high_byte_write_strobe_n))) else $error("bad strobe");
  chk_idle_quiet: assert property (o_ready |-> o_block_chip_select_n == 4'hF
    && o_address_latch_strobe && !any_strobe) else $error("idle bus not quiet");
  chk_latch_fall: assert property ($changed(o_address_latch_strobe) |-> $fell(o_bus_clock_output))
    else $error("latch strobe off the falling bus clock");
  // Wait handling: ignored when off, one extra state when on.
  chk_wait_off: assert property ($fell(o_read_strobe_n) && !i_port_cm_function_control
    |-> !o_read_strobe_n[*4] ##1 o_read_strobe_n) else $error("wait not ignored");
  chk_wait_on: assert property ($fell(o_read_strobe_n) && i_port_cm_function_control && i_wait
    && $past(i_wait, 4) |-> !o_read_strobe_n[*8]) else $error("wait state missing");
  // Bus hold sequence.
  chk_hold_sync: assert property ($rose(i_bus_hold_request) && !o_control_bus_oe_n |=> !o_control_bus_oe_n)
    else $error("hold request used unsynchronised");
  chk_hold_bound: assert property ($rose(i_bus_hold_request) |-> ##[1:60] o_bus_hold_acknowledge)
    else $error("hold never acknowledged");
  chk_hold_float: assert property (o_bus_hold_acknowledge |-> o_control_bus_oe_n
    && &(o_muxed_addr_data_bus_oe_n | ~i_ad_control_mode)) else $error("bus driven during hold");
  chk_float_first: assert property ($rose(o_bus_hold_acknowledge) |-> $past(o_control_bus_oe_n, 4))
    else $error("acknowledge before release");
  chk_ack_release: assert property ($fell(o_bus_hold_acknowledge) |-> o_control_bus_oe_n[*3])
    else $error("bus retaken too early");
  // Bus clock is high two and low two cycles; the check is off while in standby.
  chk_bclk_period: assert property (@(posedge i_clock) disable iff (!i_nrst || o_standby)
    $rose(o_bus_clock_output) |=> o_bus_clock_output ##1 !o_bus_clock_output[*2] ##1 o_bus_clock_output)
    else $error("bus clock period wrong");

  cover property ($rose(o_bus_hold_acknowledge));
  cover property ($fell(o_read_strobe_n) && i_port_cm_function_control && i_wait);
  cover property (!o_low_byte_write_strobe_n && !o_high_byte_write_strobe_n);
endmodule
`default_nettype wire

//--- ebc_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebc_map.vh"

// Memory on the far side of the multiplexed bus, one 64-word array with 16 words per block.
module ebc_ext_mem (
  // Clock on which the pins are sampled.
  input  wire logic                 i_clock,
  // Controller side of the shared lines.
  input  wire logic [`EBC_AD_W-1:0] i_ad_out,
  input  wire logic [`EBC_AD_W-1:0] i_ad_oe_n,
  // Select and strobes.
  input  wire logic [`EBC_CS_W-1:0] i_cs_n,
  input  wire logic                 i_alstb,
  input  wire logic                 i_rd_n,
  input  wire logic                 i_wr_lo_n,
  input  wire logic                 i_wr_hi_n,
  // Resolved level of the shared lines.
  output logic      [`EBC_AD_W-1:0] o_pin
);
  logic [15:0] mem [0:63];
  logic [15:0] last;
  logic [5:0]  idx;
  logic        drive;

  initial begin
    drive = 1'b0;
    last = 16'h0000;
    idx = 6'h00;
    for (int k = 0; k < 64; k++) mem[k] = 16'h0000;
  end

  // An undriven line shows the inverse of its last level, so stale data never passes for fresh.
  always @* o_pin = (i_ad_out & ~i_ad_oe_n) | ((drive ? mem[idx] : ~last) & i_ad_oe_n);
  always @(posedge i_clock) last <= o_pin;

  // The address is latched on the falling latch strobe; the select names the block.
  always @(negedge i_alstb) idx = {~i_cs_n[2] | ~i_cs_n[3], ~i_cs_n[1] | ~i_cs_n[3], o_pin[3:0]};

  // Bytes are stored while their strobe is low; read data stays out until deselect.
  always @(posedge i_clock) begin
    if (!i_wr_lo_n) mem[idx][7:0] <= o_pin[7:0];
    if (!i_wr_hi_n) mem[idx][15:8] <= o_pin[15:8];
    if (!i_rd_n) drive <= 1'b1;
    else if (i_cs_n == 4'hF) drive <= 1'b0;
  end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "ebc_map.vh"

`define EBC_CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("FAIL %0t: got %h expected %h", $time, got, exp); end end

// The checker rides on every instance of the controller.
bind ebc_bus_control ebc_bus_sva u_sva (.*);

module testbench;
  // Inputs of the controller, all set at time zero except the bus input lines, which the memory drives.
  logic        i_clock = 1'b0, i_nrst = 1'b0, i_req = 1'b0, i_write = 1'b0, i_standby_enter = 1'b0;
  logic        i_port_cm_function_control = 1'b0, i_wait = 1'b0, i_bus_hold_request = 1'b0;
  logic [1:0]  i_block = 2'h0, i_byte_en = 2'h0;
  logic [15:0] i_addr = 16'h0000, i_wdata = 16'h0000, i_ad_control_mode = 16'hFFFF;
  logic [15:0] i_port_dir_out = 16'h0000, i_port_out_data = 16'h0000;
  wire  [15:0] i_muxed_addr_data_bus;
  // Outputs of the controller.
  wire         o_ready, o_ack, o_standby, o_bus_hold_acknowledge, o_bus_clock_output, o_read_strobe_n;
  wire         o_low_byte_write_strobe_n, o_high_byte_write_strobe_n, o_address_latch_strobe, o_control_bus_oe_n;
  wire  [15:0] o_rdata, o_port_in_data, o_muxed_addr_data_bus, o_muxed_addr_data_bus_oe_n;
  wire  [3:0]  o_block_chip_select_n;
  int          num_errors = 0, tests_run = 0;
  logic [15:0] shadow [0:63];

  ebc_bus_control DUT (.*);
  ebc_ext_mem u_mem (.i_clock(i_clock), .i_ad_out(o_muxed_addr_data_bus), .i_ad_oe_n(o_muxed_addr_data_bus_oe_n),
    .i_cs_n(o_block_chip_select_n), .i_alstb(o_address_latch_strobe), .i_rd_n(o_read_strobe_n),
    .i_wr_lo_n(o_low_byte_write_strobe_n), .i_wr_hi_n(o_high_byte_write_strobe_n), .o_pin(i_muxed_addr_data_bus));

  always #50 i_clock = ~i_clock;

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A wait that ran to its bound ends the run.
  task automatic guard(input int n);
    if (n >= 200) begin
      num_errors++;
      test_done();
    end
  endtask

  // One access; wait drops two strobe cycles in, so an enabled wait adds exactly one state.
  task automatic access(input logic wr, input logic [1:0] b, input logic [15:0] a, input logic [15:0] d,
                        input logic [1:0] e, input int hold_at, input int exp_len);
    int n, slen, rlen;
    logic pas;
    tick();
    {i_write, i_block, i_addr, i_wdata, i_byte_en} = {wr, b, a, d, e};
    i_req = 1'b1;
    pas = 1'b1;
    slen = 0;
    rlen = 0;
    for (n = 0; o_ack !== 1'b1 && n < 200; n++) begin
      tick();
      if (n == hold_at) i_bus_hold_request = 1'b1;
      if (!o_address_latch_strobe && pas) `EBC_CHK({o_muxed_addr_data_bus_oe_n, o_muxed_addr_data_bus}, {16'h0, a})
      pas = o_address_latch_strobe;
      if (!(o_read_strobe_n && o_low_byte_write_strobe_n && o_high_byte_write_strobe_n)) begin
        slen++;
        rlen += !o_read_strobe_n;
        `EBC_CHK(o_block_chip_select_n, ~(4'h1 << b))
        if (wr) `EBC_CHK({o_high_byte_write_strobe_n, o_low_byte_write_strobe_n}, ~e)
      end
      if (slen == 2) i_wait = 1'b0;
    end
    guard(n);
    i_req = 1'b0;
    `EBC_CHK(slen, exp_len)
    `EBC_CHK(rlen, wr ? 0 : exp_len)
    if (!wr) `EBC_CHK(o_rdata, shadow[{b, a[3:0]}])
    if (wr) shadow[{b, a[3:0]}] = {e[1] ? d[15:8] : shadow[{b, a[3:0]}][15:8], e[0] ? d[7:0] : shadow[{b, a[3:0]}][7:0]};
  endtask

  // Wait for the hold acknowledge, check the float and refusal, then hand the bus back.
  task automatic hold_phase();
    int n;
    for (n = 0; o_bus_hold_acknowledge !== 1'b1 && n < 200; n++) tick();
    guard(n);
    `EBC_CHK({o_ready, o_control_bus_oe_n, o_muxed_addr_data_bus_oe_n}, {2'h1, 16'hFFFF})
    i_bus_hold_request = 1'b0;
    for (n = 0; o_ready !== 1'b1 && n < 200; n++) tick();
    guard(n);
  endtask

  initial begin
    logic [15:0] a;
    logic c;
    for (int k = 0; k < 64; k++) shadow[k] = 16'h0000;
    a = 16'($urandom(32'h7EFF));
    repeat (8) tick();
    `EBC_CHK({o_block_chip_select_n, o_address_latch_strobe, o_ack, o_standby}, {4'hF, 1'b1, 2'h0})
    i_nrst = 1'b1;
    repeat (8) tick();
    // Every block and byte pattern: write a word, read it back.
    for (int b = 0; b < 4; b++) begin
      for (int e = 1; e < 4; e++) begin
        a = 16'($urandom);
        access(1'b1, b[1:0], a, 16'($urandom), e[1:0], -1, 4);
        access(1'b0, b[1:0], a, 16'h0000, 2'h0, -1, 4);
      end
    end
    // Mixed traffic with the wait line and the wait function drawn at random.
    repeat (24) begin
      c = 1'($urandom);
      i_port_cm_function_control = c;
      i_wait = 1'($urandom);
      access(1'($urandom), 2'($urandom), 16'($urandom), 16'($urandom), 2'($urandom % 3 + 1), -1, (c && i_wait) ? 8 : 4);
    end
    i_port_cm_function_control = 1'b0;
    // Bus hold, first in mid-cycle, then from idle.
    access(1'b0, 2'h2, a, 16'h0000, 2'h0, 6, 4);
    hold_phase();
    i_bus_hold_request = 1'b1;
    hold_phase();
    access(1'b0, 2'h2, a, 16'h0000, 2'h0, -1, 4);
    // Upper lines as plain port pins with random direction and level.
    i_ad_control_mode = 16'h00FF;
    i_port_dir_out = 16'($urandom);
    i_port_out_data = 16'($urandom);
    repeat (8) tick();
    `EBC_CHK(o_muxed_addr_data_bus_oe_n[15:8], ~i_port_dir_out[15:8])
    `EBC_CHK(o_port_in_data[15:8] & i_port_dir_out[15:8], i_port_out_data[15:8] & i_port_dir_out[15:8])
    i_ad_control_mode = 16'hFFFF;
    // Standby is left only through reset.
    i_standby_enter = 1'b1;
    tick();
    i_standby_enter = 1'b0;
    repeat (4) tick();
    `EBC_CHK({o_standby, o_ready}, 2'h2)
    i_nrst = 1'b0;
    tick();
    `EBC_CHK(o_standby, 1'b0)
    i_nrst = 1'b1;
    repeat (8) tick();
    `EBC_CHK(o_ready, 1'b1)
    test_done();
  end

  // Last-resort limit on the whole run.
  initial begin
    #(100000 * 100);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
